// File: rtl/isps_pkg.sv
`default_nettype none
package isps_pkg;
   localparam logic [31:0] ISPS_CTRL_ADDR = 32'hF1000220;
   localparam logic [31:0] ISPS_PARAM_ADDR = 32'hF1000224;
   localparam logic [31:0] ISPS_STEP_ADDR = 32'hF1000228;
   localparam int ISPS_DEPTH = 32;
   localparam int ISPS_PW = 5;
   localparam int ISPS_PRESENCE_BIT = 0;
   localparam int ISPS_WRAP_BIT = 5;
   localparam int ISPS_ENABLE_BIT = 6;
   localparam int ISPS_SETUP_BIT = 7;
   localparam int ISPS_STORE_BIT = 5;
   localparam int ISPS_SSTEP_BIT = 5;
   localparam int ISPS_SRESET_BIT = 6;
   localparam int ISPS_MAXLEN_LSB = 16;
   localparam int ISPS_LEN_LSB = 24;
   localparam int ISPS_MODE_LSB = 8;
   localparam int ISPS_REP_LSB = 16;
   localparam int ISPS_IDX_LSB = 24;
   localparam int ISPS_POS_LSB = 24;
   localparam logic [7:0] ISPS_MODE_IMAGE = 8'h80;
   localparam logic [7:0] ISPS_MODE_EDGE = 8'h82;
   localparam logic [7:0] ISPS_MODE_LEVEL = 8'h84;
   localparam logic [7:0] ISPS_MAX_LEN = 8'h20;
   localparam logic [7:0] ISPS_LEN_RESET = 8'h20;
   localparam logic [7:0] ISPS_REP_ONE = 8'h01;
   localparam logic [1:0] ISPS_SEL_CTRL = 2'h0;
   localparam logic [1:0] ISPS_SEL_PARAM = 2'h1;
   localparam logic [1:0] ISPS_SEL_STEP = 2'h2;
   localparam logic [1:0] ISPS_SEL_NONE = 2'h3;

   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] repeat_n;
   } isps_meta_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] sel;
   } isps_dphase_t;
endpackage
`default_nettype wire

// File: rtl/isps_stepper.sv
// Our own choice: the AHB-Lite register port.
`default_nettype none
module isps_stepper
   import isps_pkg::*;
#(
   parameter int PW = 64
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // camera timing, same clock
   input wire logic integ_start,
   input wire logic capture_start,
   input wire logic [PW-1:0] live_params,
   // input line assignment
   input wire logic step_line_a_used,
   input wire logic step_line_b_used,
   input wire logic reset_line_used,
   // external input pins
   input wire logic step_line_a,
   input wire logic step_line_b,
   input wire logic reset_line,
   // image parameters and status
   output logic [PW-1:0] active_params,
   output logic sequence_running,
   output logic [ISPS_PW-1:0] pointer_position
);

   // register bus
   isps_dphase_t dphase_reg;
   logic [31:0] hrdata_reg;
   logic addr_phase;
   logic [1:0] addr_sel;
   logic [31:0] read_mux;
   logic wr_ctrl;
   logic wr_param;
   logic wr_step;

   // control state
   logic wrap_flag_reg;
   logic enable_reg;
   logic setup_flag_reg;
   logic [7:0] programmed_length_reg;
   logic [7:0] step_source_code_reg;
   logic [7:0] repeat_count_reg;
   logic [7:0] entry_index_reg;

   // entry stores
   logic [PW-1:0] params_mem [ISPS_DEPTH];
   isps_meta_t meta_mem [ISPS_DEPTH];

   // pin synchronisers
   logic [2:0] pin_raw;
   logic [2:0] pin_meta_reg;
   logic [2:0] pin_sync_reg;
   logic step_prev_reg;
   logic reset_prev_reg;
   logic step_level;
   logic step_rise;
   logic reset_rise;

   // stepping engine
   logic [ISPS_PW-1:0] ptr_reg;
   logic [ISPS_PW-1:0] ptr_next;
   logic [7:0] rep_used_reg;
   logic [7:0] rep_used_next;
   logic [7:0] rep_target;
   logic [ISPS_PW-1:0] last_idx;
   isps_meta_t cur_meta;
   logic is_edge;
   logic is_level;
   logic running;
   logic soft_step;
   logic soft_pointer_reset;
   logic restart;
   logic advance;

   // ---------------- ahb-lite slave ----------------
   assign addr_phase = hsel & hready & htrans[1];

   always_comb
   begin
      unique case (haddr)
         ISPS_CTRL_ADDR: addr_sel = ISPS_SEL_CTRL;
         ISPS_PARAM_ADDR: addr_sel = ISPS_SEL_PARAM;
         ISPS_STEP_ADDR: addr_sel = ISPS_SEL_STEP;
         default: addr_sel = ISPS_SEL_NONE;
      endcase
   end

   // only whole-word transfers are issued, so hsize is not decoded
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dphase_reg <= '0;
      end
      else
      begin
         dphase_reg.valid <= addr_phase;
         dphase_reg.write <= hwrite;
         dphase_reg.sel <= addr_sel;
      end
   end

   assign wr_ctrl = dphase_reg.valid & dphase_reg.write & (dphase_reg.sel == ISPS_SEL_CTRL);
   assign wr_param = dphase_reg.valid & dphase_reg.write & (dphase_reg.sel == ISPS_SEL_PARAM);
   assign wr_step = dphase_reg.valid & dphase_reg.write & (dphase_reg.sel == ISPS_SEL_STEP);

   always_comb
   begin
      read_mux = 32'h0000_0000;
      unique case (addr_sel)
         ISPS_SEL_CTRL:
         begin
            read_mux[ISPS_PRESENCE_BIT] = 1'b1;
            read_mux[ISPS_WRAP_BIT] = wrap_flag_reg;
            read_mux[ISPS_ENABLE_BIT] = enable_reg;
            read_mux[ISPS_SETUP_BIT] = setup_flag_reg;
            read_mux[ISPS_MAXLEN_LSB +: 8] = ISPS_MAX_LEN;
            read_mux[ISPS_LEN_LSB +: 8] = programmed_length_reg;
         end
         ISPS_SEL_PARAM:
         begin
            // store_entry always reads back zero
            read_mux[ISPS_MODE_LSB +: 8] = step_source_code_reg;
            read_mux[ISPS_REP_LSB +: 8] = repeat_count_reg;
            read_mux[ISPS_IDX_LSB +: 8] = entry_index_reg;
         end
         ISPS_SEL_STEP:
         begin
            read_mux[ISPS_PRESENCE_BIT] = 1'b1;
            read_mux[ISPS_POS_LSB +: ISPS_PW] = ptr_reg;
         end
         default: read_mux = 32'h0000_0000;
      endcase
   end

   // read data prepared in the address phase: zero wait states
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hrdata_reg <= 32'h0000_0000;
      end
      else if (addr_phase && !hwrite)
      begin
         hrdata_reg <= read_mux;
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ---------------- control registers ----------------
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wrap_flag_reg <= 1'b0;
         enable_reg <= 1'b0;
         setup_flag_reg <= 1'b0;
         programmed_length_reg <= ISPS_LEN_RESET;
      end
      else if (wr_ctrl)
      begin
         wrap_flag_reg <= hwdata[ISPS_WRAP_BIT];
         enable_reg <= hwdata[ISPS_ENABLE_BIT];
         setup_flag_reg <= hwdata[ISPS_SETUP_BIT];
         programmed_length_reg <= hwdata[ISPS_LEN_LSB +: 8];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         step_source_code_reg <= ISPS_MODE_IMAGE;
         repeat_count_reg <= 8'h00;
         entry_index_reg <= 8'h00;
      end
      else if (wr_param)
      begin
         step_source_code_reg <= hwdata[ISPS_MODE_LSB +: 8];
         repeat_count_reg <= hwdata[ISPS_REP_LSB +: 8];
         entry_index_reg <= hwdata[ISPS_IDX_LSB +: 8];
      end
   end

   // ---------------- entry stores ----------------
   // indices beyond the depth are dropped rather than aliased
   always_ff @(posedge clk_sys)
   begin
      if (wr_param && hwdata[ISPS_STORE_BIT]
          && (hwdata[ISPS_IDX_LSB +: 8] < 8'(ISPS_DEPTH)))
      begin
         params_mem[hwdata[ISPS_IDX_LSB +: ISPS_PW]] <= live_params;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < ISPS_DEPTH; i++)
         begin
            meta_mem[i] <= '{mode: ISPS_MODE_IMAGE, repeat_n: 8'h00};
         end
      end
      else if (wr_param && hwdata[ISPS_STORE_BIT]
               && (hwdata[ISPS_IDX_LSB +: 8] < 8'(ISPS_DEPTH)))
      begin
         meta_mem[hwdata[ISPS_IDX_LSB +: ISPS_PW]] <=
            '{mode: hwdata[ISPS_MODE_LSB +: 8], repeat_n: hwdata[ISPS_REP_LSB +: 8]};
      end
   end

   // ---------------- input pins ----------------
   assign pin_raw = {reset_line, step_line_b, step_line_a};

   generate
      for (genvar g = 0; g < 3; g++)
      begin : g_sync
         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
            begin
               pin_meta_reg[g] <= 1'b0;
               pin_sync_reg[g] <= 1'b0;
            end
            else
            begin
               pin_meta_reg[g] <= pin_raw[g];
               pin_sync_reg[g] <= pin_meta_reg[g];
            end
         end
      end
   endgenerate

   // no assigned line gives a low step input: edge and level entries then step by software only
   assign step_level = (pin_sync_reg[0] | ~step_line_a_used)
      & (pin_sync_reg[1] | ~step_line_b_used)
      & (step_line_a_used | step_line_b_used);

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         step_prev_reg <= 1'b0;
         reset_prev_reg <= 1'b0;
      end
      else
      begin
         step_prev_reg <= step_level;
         reset_prev_reg <= pin_sync_reg[2] & reset_line_used;
      end
   end

   assign step_rise = step_level & ~step_prev_reg;
   assign reset_rise = pin_sync_reg[2] & reset_line_used & ~reset_prev_reg;

   // ---------------- stepping engine ----------------
   assign running = enable_reg & ~setup_flag_reg;
   assign soft_step = wr_step & hwdata[ISPS_SSTEP_BIT];
   assign soft_pointer_reset = wr_step & hwdata[ISPS_SRESET_BIT];
   assign restart = capture_start | soft_pointer_reset | reset_rise;
   assign cur_meta = meta_mem[ptr_reg];
   assign is_edge = (cur_meta.mode == ISPS_MODE_EDGE);
   assign is_level = (cur_meta.mode == ISPS_MODE_LEVEL);
   assign rep_target = (cur_meta.repeat_n == 8'h00) ? ISPS_REP_ONE : cur_meta.repeat_n;

   // a length of zero gives a one-entry sequence; a length beyond the depth is clamped to the store
   assign last_idx = (programmed_length_reg == 8'h00) ? ISPS_PW'(0)
      : (programmed_length_reg > 8'(ISPS_DEPTH)) ? ISPS_PW'(ISPS_DEPTH - 1)
      : ISPS_PW'(programmed_length_reg - 8'h01);

   // level input is sampled at each image start; on level entries, apart from a software step, the pointer advances only while it is high
   always_comb
   begin
      advance = 1'b0;
      if (running)
      begin
         if (soft_step)
         begin
            advance = 1'b1;
         end
         else if (is_edge)
         begin
            advance = step_rise;
         end
         else if (is_level)
         begin
            advance = step_level & integ_start;
         end
         else
         begin
            advance = integ_start;
         end
      end
   end

   always_comb
   begin
      ptr_next = ptr_reg;
      rep_used_next = rep_used_reg;
      if (restart)
      begin
         ptr_next = '0;
         rep_used_next = 8'h00;
      end
      else if (advance)
      begin
         if (rep_used_reg + 8'h01 < rep_target)
         begin
            rep_used_next = rep_used_reg + 8'h01;
         end
         else
         begin
            rep_used_next = 8'h00;
            if (ptr_reg != last_idx)
            begin
               ptr_next = ptr_reg + ISPS_PW'(1);
            end
            else if (wrap_flag_reg)
            begin
               ptr_next = '0;
            end
            else
            begin
               ptr_next = ptr_reg;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ptr_reg <= '0;
         rep_used_reg <= 8'h00;
      end
      else
      begin
         ptr_reg <= ptr_next;
         rep_used_reg <= rep_used_next;
      end
   end

   // running, parameters change only at image start so a frame never mixes sets; stopped, they follow live_params
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         active_params <= '0;
      end
      else if (!running)
      begin
         active_params <= live_params;
      end
      else if (integ_start)
      begin
         active_params <= params_mem[ptr_reg];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sequence_running <= 1'b0;
         pointer_position <= '0;
      end
      else
      begin
         sequence_running <= running;
         pointer_position <= ptr_next;
      end
   end

endmodule
`default_nettype wire

// File: testbench/isps_stepper_asserts.sv
`default_nettype none
module isps_chk
   import isps_pkg::*;
#(
   parameter int PW = 64
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // image side
   input wire logic integ_start,
   input wire logic capture_start,
   input wire logic [PW-1:0] live_params,
   input wire logic [PW-1:0] active_params,
   input wire logic sequence_running,
   input wire logic [ISPS_PW-1:0] pointer_position
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic rd;
   assign rd = hsel && hready && htrans[1] && !hwrite;
   a_ctrl_ro: assert property (rd && haddr == ISPS_CTRL_ADDR |=>
      hrdata[0] && hrdata[23:16] == ISPS_MAX_LEN && hrdata[15:8] == 8'h00)
      else $error("control read-only bits wrong");
   a_step_ro: assert property (rd && haddr == ISPS_STEP_ADDR |=>
      hrdata[0] && hrdata[23:7] == 17'h00000) else $error("step read bits wrong");
   a_param_self: assert property (rd && haddr == ISPS_PARAM_ADDR |=>
      hrdata[7:0] == 8'h00) else $error("store bit does not read zero");
   a_idle_follow: assert property (!sequence_running [*3] |->
      active_params == $past(live_params)) else $error("idle params not live");
   a_restart_zero: assert property (capture_start |-> ##[0:1]
      pointer_position == 5'h00) else $error("capture start kept pointer");
   a_ptr_moves: assert property ($changed(pointer_position) |->
      pointer_position == $past(pointer_position) + 1 || pointer_position == 5'h00)
      else $error("pointer jumped");
   a_ptr_idle: assert property (!sequence_running ##1
      (!sequence_running && $changed(pointer_position)) |-> pointer_position == 5'h00)
      else $error("pointer stepped while off");
   // parameters change only at an image start once running
   a_hold_params: assert property ((sequence_running [*3] ##0 !$past(integ_start)) |->
      $stable(active_params)) else $error("params moved between images");
   c_run: cover property ($rose(sequence_running));
   c_wrap: cover property (pointer_position == 5'h01 ##[1:40] pointer_position == 5'h00);
   c_restart: cover property (capture_start && sequence_running);
endmodule
`default_nettype wire

// File: testbench/isps_line_model.sv
`default_nettype none
module isps_line_model
(
   // clock
   input wire logic clk_sys,
   // wanted line levels
   input wire logic want_a,
   input wire logic want_b,
   input wire logic want_r,
   // pins
   output logic step_line_a,
   output logic step_line_b,
   output logic reset_line
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      step_line_a = 1'b0;
      step_line_b = 1'b0;
      reset_line = 1'b0;
   end
   // pins move off the clock grid, as real lines do
   always @(posedge clk_sys)
   begin
      step_line_a <= #3 want_a;
      step_line_b <= #3 want_b;
      reset_line <= #3 want_r;
   end
endmodule
`default_nettype wire

// File: testbench/isps_stepper_tb_top.sv
`default_nettype none
module isps_stepper_tb_top
   import isps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PW = 64;
   logic clk_sys, rst_n, hsel, hwrite, hreadyout, hresp, integ_start, capture_start;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [PW-1:0] live_params, active_params;
   logic a_used, b_used, r_used, want_a, want_b, want_r, line_a, line_b, line_r;
   logic sequence_running;
   logic [ISPS_PW-1:0] pointer_position;
   logic [15:0] tbl [6] = '{16'h8000, 16'h8002, 16'h8201, 16'h8401, 16'h5501, 16'h8001};
   int errors, samples_checked;
   isps_stepper #(.PW(PW)) isps_stepper_i (.clk_sys, .rst_n, .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
      .integ_start, .capture_start, .live_params, .step_line_a_used(a_used),
      .step_line_b_used(b_used), .reset_line_used(r_used), .step_line_a(line_a),
      .step_line_b(line_b), .reset_line(line_r), .active_params, .sequence_running,
      .pointer_position);
   isps_line_model isps_line_model_i (.clk_sys, .want_a, .want_b, .want_r,
      .step_line_a(line_a), .step_line_b(line_b), .reset_line(line_r));
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic give_verdict();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rdy();
      int n;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clk_sys);
         if (hreadyout === 1'b1)
            break;
      end
      if (n >= 50)
      begin
         errors++;
         give_verdict();
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      rdy();
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      q = hrdata;
      chk("hresp", 64'h0, 64'(hresp));
   endtask
   task automatic settle(input logic [4:0] p);
      repeat (6) @(posedge clk_sys);
      #1 chk("pointer", 64'(p), 64'(pointer_position));
      @(posedge clk_sys);
   endtask
   task automatic img(input logic [4:0] p, input logic [7:0] e);
      integ_start <= 1'b1;
      @(posedge clk_sys);
      integ_start <= 1'b0;
      @(posedge clk_sys);
      #1 chk("pointer", 64'(p), 64'(pointer_position));
      chk("active", 64'hA0 + 64'(e), active_params);
      @(posedge clk_sys);
   endtask
   task automatic s_regs();
      bus(1'b0, ISPS_CTRL_ADDR, 32'h0);
      chk("ctrl", 64'h20200001, 64'(q));
      bus(1'b0, ISPS_STEP_ADDR, 32'h0);
      chk("step", 64'h00000001, 64'(q));
      bus(1'b0, ISPS_PARAM_ADDR, 32'h0);
      chk("param", 64'h00008000, 64'(q));
      bus(1'b1, ISPS_CTRL_ADDR, 32'h06000000);
      bus(1'b0, ISPS_CTRL_ADDR, 32'h0);
      chk("ctrl ro", 64'h06200001, 64'(q));
      bus(1'b1, 32'hF100022C, 32'hFFFFFFFF);
      bus(1'b0, 32'hF100022C, 32'h0);
      chk("unmapped", 64'h0, 64'(q));
   endtask
   task automatic s_load();
      for (int i = 0; i < 6; i++)
      begin
         live_params <= 64'hA0 + 64'(i);
         bus(1'b1, ISPS_PARAM_ADDR, {8'(i), tbl[i][7:0], tbl[i][15:8], 8'h20});
      end
      bus(1'b0, ISPS_PARAM_ADDR, 32'h0);
      chk("param", 64'h05018000, 64'(q));
      bus(1'b1, ISPS_CTRL_ADDR, 32'h060000C0);
      live_params <= 64'h77;
      settle(5'h00);
      chk("setup", 64'h77, active_params);
      chk("run", 64'h0, 64'(sequence_running));
      bus(1'b1, ISPS_CTRL_ADDR, 32'h06000040);
      settle(5'h00);
      chk("run", 64'h1, 64'(sequence_running));
   endtask
   task automatic s_run();
      img(5'h01, 8'h00);
      img(5'h01, 8'h01);
      img(5'h02, 8'h01);
      img(5'h02, 8'h02);
      a_used <= 1'b1;
      b_used <= 1'b1;
      want_a <= 1'b1;
      settle(5'h02);
      want_b <= 1'b1;
      settle(5'h03);
      want_b <= 1'b0;
      b_used <= 1'b0;
      want_a <= 1'b0;
      settle(5'h03);
      img(5'h03, 8'h03);
      want_a <= 1'b1;
      settle(5'h03);
      img(5'h04, 8'h03);
      want_a <= 1'b0;
      a_used <= 1'b0;
      img(5'h05, 8'h04);
      img(5'h05, 8'h05);
      capture_start <= 1'b1;
      @(posedge clk_sys);
      capture_start <= 1'b0;
      settle(5'h00);
      bus(1'b1, ISPS_STEP_ADDR, 32'h20);
      settle(5'h01);
      bus(1'b1, ISPS_STEP_ADDR, 32'h20);
      settle(5'h01);
      bus(1'b1, ISPS_STEP_ADDR, 32'h20);
      bus(1'b0, ISPS_STEP_ADDR, 32'h0);
      chk("step", 64'h02000001, 64'(q));
      bus(1'b1, ISPS_STEP_ADDR, 32'h20);
      settle(5'h03);
      bus(1'b1, ISPS_STEP_ADDR, 32'h20);
      settle(5'h04);
      bus(1'b1, ISPS_STEP_ADDR, 32'h40);
      settle(5'h00);
      bus(1'b1, ISPS_CTRL_ADDR, 32'h02000060);
      img(5'h01, 8'h00);
      img(5'h01, 8'h01);
      img(5'h00, 8'h01);
      bus(1'b1, ISPS_STEP_ADDR, 32'h20);
      settle(5'h01);
      r_used <= 1'b1;
      want_r <= 1'b1;
      settle(5'h00);
      want_r <= 1'b0;
      bus(1'b1, ISPS_STEP_ADDR, 32'h20);
      bus(1'b1, ISPS_CTRL_ADDR, 32'h02000020);
      settle(5'h01);
      capture_start <= 1'b1;
      @(posedge clk_sys);
      capture_start <= 1'b0;
      settle(5'h00);
      chk("run", 64'h0, 64'(sequence_running));
   endtask
   initial
   begin
      {rst_n, hsel, hwrite, integ_start, capture_start} = '0;
      {haddr, hwdata, htrans, live_params} = '0;
      {a_used, b_used, r_used, want_a, want_b, want_r} = '0;
      errors = 0;
      samples_checked = 0;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      s_regs();
      s_load();
      s_run();
      give_verdict();
   end
endmodule
bind isps_stepper isps_chk #(.PW(PW)) isps_chk_i (.clk_sys, .rst_n, .hsel, .haddr, .htrans,
   .hwrite, .hready, .hrdata, .integ_start, .capture_start, .live_params, .active_params,
   .sequence_running, .pointer_position);
`default_nettype wire
